/* logic/mac_dp_pkg.sv */
`default_nettype none
package mac_dp_pkg;
   // =====================================================
   // register map (byte addresses)
   localparam logic [3:0]  MODE_OFS      = 4'h0;
   localparam logic [3:0]  STATUS_OFS    = 4'h4;
   localparam logic [3:0]  SHIFT_OFS     = 4'h8;
   localparam logic [3:0]  TEMP3_OFS     = 4'hC;
   // =====================================================
   // mode register fields
   localparam int          FRACT_BIT     = 0;
   localparam int          SATURATE_MULTIPLY_MODE_BIT      = 1;
   localparam int          RND_BIT       = 2;
   localparam int          WIDE_BIT      = 3;
   localparam int          DSAT_BIT      = 4;
   localparam int          SXT_BIT       = 5;
   localparam int          SST_BIT       = 6;
   localparam int          LEGACY_BIT    = 7;
   localparam logic [7:0]  MODE_RESET    = 8'h20;
   // status register fields
   localparam int          OVA_BIT       = 0;
   localparam int          OVB_BIT       = 1;
   // =====================================================
   // datapath constants
   localparam int          ACC_W         = 40;
   localparam int          OPND_W        = 17;
   localparam logic [15:0] MIN_OPND      = 16'h8000;
   localparam logic [31:0] PROD_SAT      = 32'h7FFF_FFFF;
   localparam logic [40:0] ROUND_ADD     = 41'h000_0000_8000;
   localparam logic [15:0] ROUND_HALF    = 16'h8000;
   localparam logic [39:0] SAT40_POS     = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] SAT40_NEG     = 40'h80_0000_0000;
   localparam logic [39:0] SAT32_POS     = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SAT32_NEG     = 40'hFF_8000_0000;
   localparam logic [15:0] USAT_MAX      = 16'hFFFF;
   localparam logic [15:0] SSAT_POS      = 16'h7FFF;
   localparam logic [15:0] SSAT_NEG      = 16'h8000;
   localparam logic signed [6:0] SH_MAX  = 7'sd31;
   localparam logic signed [6:0] SH_MIN  = -7'sd32;
   localparam logic signed [6:0] SH_WRAP = 7'sd16;
   localparam logic [6:0]  EXP_BIAS      = 7'd8;
   // =====================================================
   // operation kinds, one-hot
   typedef enum logic [2:0] {
      OP_MAC_LOAD  = 3'b001,
      OP_MAC_STORE = 3'b010,
      OP_MANTISSA_COMPUTE_EXP  = 3'b100
   } op_kind_t;
   // =====================================================
   // block state
   typedef struct packed {
      logic [39:0] acc_a;
      logic [39:0] acc_b;
      logic        ov_a;
      logic        ov_b;
      logic [15:0] t3;
      logic [15:0] st_data;
      logic        st_en;
      logic [15:0] exp;
      logic        exp_we;
      logic        done;
      logic [7:0]  mode;
      logic [15:0] shcnt;
      logic        wait_n;
      logic [31:0] rdata;
   } state_t;
endpackage : mac_dp_pkg
`default_nettype wire

/* logic/mac_parallel_load_store_datapath.sv */
// What this block does
// - multiplier inputs sign-extended to 17 bits
// - fractional mode doubles the product
// - multiply overflow per saturate-multiply mode
// - product sign-extended, added into accumulator
// - optional rounding per rounding mode
// - add overflow width per wide mode, flag
// - saturate accumulator on overflow if enabled
// - optionally copy memory operand to temp3
// - load variant: operand shifted left 16
// - loaded value sign or zero extended
// - store shifted accumulator bits 31..16
// - shift count clamped to -32..+31
// - store shift extension per sign mode
// - legacy mode: count from low six bits
// - legacy: -32..-17 wraps modulo 16
// - store saturation unsigned when unsigned mode
// - store saturation signed when signed mode
// - mac and load/store in one cycle
// - paired op repeatable back to back
// - exponent is 8 minus sign-bit count
// - exponent signed, range -31 to 8
`default_nettype none
module mac_parallel_load_store_datapath
   import mac_dp_pkg::*;
(
   input  wire logic        clk_i,                       // core clock
   input  wire logic        resetn_i,                    // async reset, low
   input  wire logic        op_valid_i,                  // issue operation
   input  wire logic [2:0]  op_kind_i,                   // op_kind_t code
   input  wire logic        round_en_i,                  // rounding keyword
   input  wire logic        t3_write_i,                  // copy xmem to temp3
   input  wire logic [15:0] temp_i,                      // temporary operand
   input  wire logic [15:0] xmem_i,                      // first mem operand
   input  wire logic [15:0] ymem_i,                      // second mem operand
   input  wire logic [1:0]  acc_wr_i,                    // preset acc a/b
   input  wire logic [39:0] acc_wdata_i,                 // preset value
   input  wire logic [3:0]  avs_address_i,               // byte address
   input  wire logic        avs_read_i,                  // read request
   input  wire logic        avs_write_i,                 // write request
   input  wire logic [31:0] avs_writedata_i,             // write data
   input  wire logic [3:0]  avs_byteenable_i,            // byte lanes
   output logic      [31:0] avs_readdata_o,              // read data
   output logic             avs_waitrequest_o,           // stall
   output logic      [39:0] first_accumulator_o,         // mac accumulator
   output logic      [39:0] second_accumulator_o,        // load/store acc
   output logic             first_acc_overflow_flag_o,   // sticky overflow
   output logic             second_acc_overflow_flag_o,  // never set, stays 0
   output logic      [15:0] third_temp_register_o,       // temp3
   output logic      [15:0] store_data_o,                // data to ymem
   output logic             store_en_o,                  // store strobe
   output logic      [15:0] exp_o,                       // exponent
   output logic             exp_we_o,                    // exponent strobe
   output logic             done_o                       // op completed
);

   // =====================================================
   // helpers
   function automatic logic [5:0] sign_bits(input logic [39:0] v);
      logic [5:0] n;
      logic       run;
      n   = 6'd0;
      run = 1'b1;
      for (int i = 38; i >= 0; i--) begin
         if (run && (v[i] == v[39])) begin
            n = n + 6'd1;
         end else begin
            run = 1'b0;
         end
      end
      return n;
   endfunction : sign_bits

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      return a == ofs;
   endfunction : hit

   // =====================================================
   // state
   state_t st;
   state_t nx;

   logic                fractional_mode;
   logic                saturate_multiply_mode;
   logic                rounding_mode_select;
   logic                wide;
   logic                dsat;
   logic                sxt;
   logic                store_saturation_bit;
   logic                legacy;
   logic signed [16:0]  a17;
   logic signed [16:0]  b17;
   logic signed [33:0]  prod34;
   logic        [31:0]  prod32;
   logic        [40:0]  sum41;
   logic        [40:0]  rnd41;
   logic                add_ov;
   logic        [39:0]  mac_res;
   logic        [39:0]  load_val;
   logic signed [6:0]   cnt;
   logic signed [6:0]   c6;
   logic        [6:0]   nsh;
   logic signed [71:0]  w72;
   logic        [15:0]  st_word;
   logic        [5:0]   nsb;
   logic        [39:0]  mantissa_compute;
   logic                req;
   logic                is_mac;

   assign fractional_mode   = st.mode[FRACT_BIT];
   assign saturate_multiply_mode   = st.mode[SATURATE_MULTIPLY_MODE_BIT];
   assign rounding_mode_select    = st.mode[RND_BIT];
   assign wide   = st.mode[WIDE_BIT];
   assign dsat   = st.mode[DSAT_BIT];
   assign sxt    = st.mode[SXT_BIT];
   assign store_saturation_bit    = st.mode[SST_BIT];
   assign legacy = st.mode[LEGACY_BIT];

   // =====================================================
   // multiply-accumulate
   always_comb begin
      a17    = {temp_i[15], temp_i};
      b17    = {xmem_i[15], xmem_i};
      prod34 = a17 * b17;
      prod32 = prod34[31:0];
      if (fractional_mode) begin
         prod32 = {prod34[30:0], 1'b0};
      end
      if (saturate_multiply_mode && fractional_mode && temp_i == MIN_OPND && xmem_i == MIN_OPND) begin
         prod32 = PROD_SAT;
      end
      sum41 = {st.acc_a[39], st.acc_a} + {{9{prod32[31]}}, prod32};
      rnd41 = sum41 + ROUND_ADD;
      rnd41[15:0] = 16'h0000;
      if (rounding_mode_select && sum41[15:0] == ROUND_HALF) begin
         rnd41[16] = 1'b0;
      end
      if (round_en_i) begin
         sum41 = rnd41;
      end
      if (wide) begin
         add_ov = sum41[40] != sum41[39];
      end else begin
         add_ov = !((&sum41[40:31]) || !(|sum41[40:31]));
      end
      mac_res = sum41[39:0];
      if (add_ov && dsat) begin
         if (sum41[40]) begin
            mac_res = wide ? SAT40_NEG : SAT32_NEG;
         end else begin
            mac_res = wide ? SAT40_POS : SAT32_POS;
         end
      end
   end

   // =====================================================
   // parallel load and store
   always_comb begin
      load_val = {{8{sxt & ymem_i[15]}}, ymem_i, 16'h0000};
      c6       = {st.shcnt[5], st.shcnt[5:0]};
      if (legacy) begin
         cnt = c6;
         if (c6 < -SH_WRAP) begin
            cnt = c6 + SH_WRAP;
         end
      end else begin
         if ($signed(st.shcnt) > 16'(SH_MAX)) begin
            cnt = SH_MAX;
         end else if ($signed(st.shcnt) < $signed(16'(SH_MIN))) begin
            cnt = SH_MIN;
         end else begin
            cnt = st.shcnt[6:0];
         end
      end
      nsh = 7'(-cnt);
      w72 = {{32{sxt & st.acc_b[39]}}, st.acc_b};
      if (cnt >= 0) begin
         w72 = w72 << cnt;
      end else begin
         w72 = w72 >>> nsh;
      end
      st_word = w72[31:16];
      if (store_saturation_bit && !sxt) begin
         if (|w72[71:32]) begin
            st_word = USAT_MAX;
         end
      end else if (store_saturation_bit) begin
         if (!((&w72[71:31]) || !(|w72[71:31]))) begin
            st_word = w72[71] ? SSAT_NEG : SSAT_POS;
         end
      end
   end

   // =====================================================
   // mantissa and exponent
   always_comb begin
      nsb = sign_bits(st.acc_a);
      if ({1'b0, nsb} >= EXP_BIAS) begin
         mantissa_compute = st.acc_a << ({1'b0, nsb} - EXP_BIAS);
      end else begin
         mantissa_compute = 40'($signed(st.acc_a) >>> (EXP_BIAS - {1'b0, nsb}));
      end
   end

   // =====================================================
   // next state
   always_comb begin
      nx        = st;
      nx.st_en  = 1'b0;
      nx.exp_we = 1'b0;
      nx.done   = 1'b0;
      req       = avs_read_i || avs_write_i;
      is_mac    = op_kind_i == OP_MAC_LOAD || op_kind_i == OP_MAC_STORE;

      // bus: one wait cycle, then answer
      nx.wait_n = 1'b0;
      if (req && !st.wait_n) begin
         nx.wait_n = 1'b1;
         nx.rdata  = 32'h0000_0000;
         if (hit(avs_address_i, MODE_OFS)) begin
            nx.rdata[7:0] = st.mode;
         end else if (hit(avs_address_i, STATUS_OFS)) begin
            nx.rdata[OVA_BIT] = st.ov_a;
            nx.rdata[OVB_BIT] = st.ov_b;
         end else if (hit(avs_address_i, SHIFT_OFS)) begin
            nx.rdata[15:0] = st.shcnt;
         end else if (hit(avs_address_i, TEMP3_OFS)) begin
            nx.rdata[15:0] = st.t3;
         end
      end
      if (avs_write_i && st.wait_n) begin
         if (hit(avs_address_i, MODE_OFS) && avs_byteenable_i[0]) begin
            nx.mode = avs_writedata_i[7:0];
         end
         if (hit(avs_address_i, STATUS_OFS) && avs_byteenable_i[0]) begin
            if (avs_writedata_i[OVA_BIT]) begin
               nx.ov_a = 1'b0;
            end
            if (avs_writedata_i[OVB_BIT]) begin
               nx.ov_b = 1'b0;
            end
         end
         if (hit(avs_address_i, SHIFT_OFS)) begin
            if (avs_byteenable_i[0]) begin
               nx.shcnt[7:0] = avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
               nx.shcnt[15:8] = avs_writedata_i[15:8];
            end
         end
      end

      // accumulator preset from decode
      if (acc_wr_i[0]) begin
         nx.acc_a = acc_wdata_i;
      end
      if (acc_wr_i[1]) begin
         nx.acc_b = acc_wdata_i;
      end

      if (op_valid_i) begin
         nx.done = 1'b1;
         case (op_kind_i)
            OP_MAC_LOAD: begin
               nx.acc_a = mac_res;
               nx.acc_b = load_val;
            end
            OP_MAC_STORE: begin
               nx.acc_a   = mac_res;
               nx.st_data = st_word;
               nx.st_en   = 1'b1;
            end
            OP_MANTISSA_COMPUTE_EXP: begin
               nx.acc_b  = mantissa_compute;
               nx.exp    = 16'($signed({10'd0, EXP_BIAS}) - $signed({10'd0, nsb}));
               nx.exp_we = 1'b1;
            end
            default: begin
               nx.done = 1'b0;
            end
         endcase
         if (is_mac && add_ov) begin
            nx.ov_a = 1'b1;
         end
         if (is_mac && t3_write_i) begin
            nx.t3 = xmem_i;
         end
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st         <= '0;
         st.mode    <= MODE_RESET;
      end else begin
         st <= nx;
      end
   end

   // =====================================================
   // outputs
   assign avs_readdata_o             = st.rdata;
   assign avs_waitrequest_o          = !st.wait_n;
   assign first_accumulator_o        = st.acc_a;
   assign second_accumulator_o       = st.acc_b;
   assign first_acc_overflow_flag_o  = st.ov_a;
   assign second_acc_overflow_flag_o = st.ov_b;
   assign third_temp_register_o      = st.t3;
   assign store_data_o               = st.st_data;
   assign store_en_o                 = st.st_en;
   assign exp_o                      = st.exp;
   assign exp_we_o                   = st.exp_we;
   assign done_o                     = st.done;

endmodule : mac_parallel_load_store_datapath
`default_nettype wire

/* testbench/mac_dp_properties.sv */
`default_nettype none
module mac_dp_properties (
   input wire logic        clk_i,                     // clock
   input wire logic        resetn_i,                  // reset, low
   input wire logic        op_valid_i,                // issue
   input wire logic [2:0]  op_kind_i,                 // kind
   input wire logic        t3_write_i,                // temp3 copy
   input wire logic [15:0] xmem_i,                    // operand x
   input wire logic [15:0] ymem_i,                    // operand y
   input wire logic [39:0] second_accumulator_o,      // acc b
   input wire logic        first_acc_overflow_flag_o, // ov a
   input wire logic [15:0] third_temp_register_o,     // temp3
   input wire logic        store_en_o,                // store strobe
   input wire logic [15:0] exp_o,                     // exponent
   input wire logic        exp_we_o,                  // exp strobe
   input wire logic        done_o                     // done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ==============================
   // issue sequences
   sequence s_op(k);
      op_valid_i && op_kind_i == k;
   endsequence
   sequence s_legal;
      op_valid_i && op_kind_i inside {3'b001, 3'b010, 3'b100};
   endsequence
   // ==============================
   // properties
   property p_done;
      s_legal |=> done_o;
   endproperty
   a_done: assert property (p_done) else $error("done missing");
   property p_refuse;
      op_valid_i && !(op_kind_i inside {3'b001, 3'b010, 3'b100}) |=> !done_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("done on bad kind");
   property p_store;
      s_op(3'b010) |=> store_en_o && done_o;
   endproperty
   a_store: assert property (p_store) else $error("store strobe missing");
   property p_strobe;
      store_en_o |-> $past(op_valid_i && op_kind_i == 3'b010);
   endproperty
   a_strobe: assert property (p_strobe) else $error("stray store strobe");
   property p_exp;
      s_op(3'b100) |=> exp_we_o && $signed(exp_o) >= -31 && $signed(exp_o) <= 8;
   endproperty
   a_exp: assert property (p_exp) else $error("exponent bad");
   property p_load;
      s_op(3'b001) |=> second_accumulator_o[31:0] == {$past(ymem_i), 16'h0000};
   endproperty
   a_load: assert property (p_load) else $error("load value bad");
   property p_t3;
      s_op(3'b001) ##0 t3_write_i |=> third_temp_register_o == $past(xmem_i);
   endproperty
   a_t3: assert property (p_t3) else $error("temp3 copy bad");
   property p_ovf;
      $rose(first_acc_overflow_flag_o) |-> $past(op_valid_i && op_kind_i inside {3'b001, 3'b010});
   endproperty
   a_ovf: assert property (p_ovf) else $error("flag set without mac");
endmodule : mac_dp_properties
`default_nettype wire

/* testbench/dmem_model.sv */
`default_nettype none
module dmem_model (
   input  wire logic        clk_i,        // clock
   input  wire logic        store_en_i,   // store strobe
   input  wire logic [15:0] store_data_i, // stored word
   output logic      [15:0] last_o,       // last word kept
   output int               count_o = 0   // writes seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==============================
   // memory write port
   always @(posedge clk_i) begin
      if (store_en_i) begin
         last_o <= store_data_i;
         count_o <= count_o + 1;
      end
   end
endmodule : dmem_model
`default_nettype wire

/* testbench/tb_mac_parallel_load_store_datapath.sv */
`default_nettype none
module tb_mac_parallel_load_store_datapath
   import mac_dp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0, resetn_i = 1'b0, op_valid_i = 1'b0, round_en_i = 1'b0, t3_write_i = 1'b0;
   logic        avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o, store_en_o, exp_we_o, done_o;
   logic        first_acc_overflow_flag_o, second_acc_overflow_flag_o;
   logic [1:0]  acc_wr_i = 2'h0;
   logic [2:0]  op_kind_i = 3'h0;
   logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
   logic [15:0] temp_i = 16'h0, xmem_i = 16'h0, ymem_i = 16'h0, third_temp_register_o, store_data_o, exp_o;
   logic [15:0] last_st;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
   logic [39:0] acc_wdata_i = 40'h0, first_accumulator_o, second_accumulator_o;
   int          errors = 0, num_checks = 0, n_st = 0, n_seen;

   mac_parallel_load_store_datapath dut (.*);
   dmem_model mem (.clk_i(clk_i), .store_en_i(store_en_o), .store_data_i(store_data_o), .last_o(last_st),
                   .count_o(n_seen));

   always #20 clk_i = ~clk_i;
   // ==============================
   // access tasks
   task automatic chk(input string nm, input logic [39:0] e, g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, e);
      @(posedge clk_i);
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (!w) chk("reg", {8'h00, e}, {8'h00, avs_readdata_o});
   endtask : bus

   task automatic pre(input logic [1:0] s, input logic [39:0] v);
      @(posedge clk_i);
      acc_wr_i <= s;
      acc_wdata_i <= v;
      @(posedge clk_i);
      acc_wr_i <= 2'h0;
   endtask : pre

   task automatic op(input logic [2:0] k, input logic [15:0] t, x, y, input logic r, w, input int n);
      @(posedge clk_i);
      op_valid_i <= 1'b1;
      op_kind_i <= k;
      temp_i <= t;
      xmem_i <= x;
      ymem_i <= y;
      round_en_i <= r;
      t3_write_i <= w;
      repeat (n) @(posedge clk_i);
      op_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("done", {39'h0, k inside {3'b001, 3'b010, 3'b100}}, {39'h0, done_o});
   endtask : op

   task automatic mac(input logic [7:0] m, input logic r, input logic [39:0] a, input logic [15:0] t, x,
                      input logic [39:0] e);
      bus(1'b1, MODE_OFS, {24'h00_0000, m}, 32'h0);
      pre(2'h1, a);
      op(3'b001, t, x, 16'h0, r, 1'b0, 1);
      chk("acc_a", e, first_accumulator_o);
   endtask : mac

   task automatic st(input logic [7:0] m, input logic [15:0] s, input logic [39:0] a, input logic [15:0] e);
      bus(1'b1, MODE_OFS, {24'h00_0000, m}, 32'h0);
      bus(1'b1, SHIFT_OFS, {16'h0000, s}, 32'h0);
      pre(2'h2, a);
      op(3'b010, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1);
      chk("store", {24'h00_0000, e}, {24'h00_0000, store_data_o});
      n_st++;
   endtask : st

   task automatic mx(input logic [39:0] a, input logic [15:0] ex, input logic [39:0] mn);
      pre(2'h1, a);
      op(3'b100, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1);
      chk("exp", {24'h00_0000, ex}, {24'h00_0000, exp_o});
      chk("mantissa_compute", mn, second_accumulator_o);
   endtask : mx

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // ==============================
   // watchdog
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
   // ==============================
   // test sequence
   initial begin
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      bus(1'b0, MODE_OFS, 32'h0, 32'h0000_0020);
      bus(1'b0, 4'h2, 32'h0, 32'h0);
      bus(1'b1, TEMP3_OFS, 32'h0000_1111, 32'h0);
      pre(2'h3, 40'h0);
      op(3'b001, 16'h0003, 16'hFFFE, 16'h8001, 1'b0, 1'b1, 1);
      chk("acc_a", 40'hFF_FFFF_FFFA, first_accumulator_o);
      chk("acc_b", 40'hFF_8001_0000, second_accumulator_o);
      chk("t3", 40'hFFFE, {24'h00_0000, third_temp_register_o});
      bus(1'b0, TEMP3_OFS, 32'h0, 32'h0000_FFFE);
      bus(1'b1, MODE_OFS, 32'h0, 32'h0);
      op(3'b001, 16'h0, 16'h0, 16'h8001, 1'b0, 1'b0, 1);
      chk("acc_b", 40'h00_8001_0000, second_accumulator_o);
      op(3'b011, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1);
      mac(8'h01, 1'b0, 40'h0, 16'h4000, 16'h4000, 40'h00_2000_0000);
      mac(8'h03, 1'b0, 40'h0, 16'h8000, 16'h8000, 40'h00_7FFF_FFFF);
      mac(8'h20, 1'b1, 40'h00_0002_8000, 16'h0, 16'h0, 40'h00_0003_0000);
      mac(8'h24, 1'b1, 40'h00_0002_8000, 16'h0, 16'h0, 40'h00_0002_0000);
      chk("ov_a", 40'h0, {39'h0, first_acc_overflow_flag_o});
      mac(8'h20, 1'b0, 40'h00_7FFF_FFFF, 16'h1, 16'h1, 40'h00_8000_0000);
      chk("ov_a", 40'h1, {39'h0, first_acc_overflow_flag_o});
      chk("ov_b", 40'h0, {39'h0, second_acc_overflow_flag_o});
      bus(1'b0, STATUS_OFS, 32'h0, 32'h1);
      bus(1'b1, STATUS_OFS, 32'h1, 32'h0);
      mac(8'h30, 1'b0, 40'h00_7FFF_FFFF, 16'h1, 16'h1, 40'h00_7FFF_FFFF);
      bus(1'b1, STATUS_OFS, 32'h1, 32'h0);
      mac(8'h38, 1'b0, 40'h00_7FFF_FFFF, 16'h1, 16'h1, 40'h00_8000_0000);
      bus(1'b0, STATUS_OFS, 32'h0, 32'h0);
      mac(8'h38, 1'b0, 40'h7F_FFFF_FFFF, 16'h1, 16'h1, 40'h7F_FFFF_FFFF);
      pre(2'h1, 40'h0);
      op(3'b001, 16'h0002, 16'h0003, 16'h0, 1'b0, 1'b0, 3);
      chk("acc_a", 40'h12, first_accumulator_o);
      st(8'h20, 16'h0000, 40'h00_1234_5678, 16'h1234);
      st(8'h20, 16'h0004, 40'h00_1234_5678, 16'h2345);
      st(8'h20, 16'hFFFC, 40'h00_1234_5678, 16'h0123);
      st(8'h20, 16'h0040, 40'h00_1234_5679, 16'h8000);
      st(8'h00, 16'hFFF0, 40'hFF_8000_0000, 16'h00FF);
      st(8'hA0, 16'hFFE0, 40'h12_3456_7800, 16'h0012);
      st(8'hA0, 16'h0044, 40'h12_3456_7800, 16'h4567);
      st(8'h60, 16'h0008, 40'h00_1234_5678, 16'h7FFF);
      st(8'h40, 16'h0000, 40'hFF_0000_0000, 16'hFFFF);
      mx(40'h21_0A0A_0A0A, 16'h0007, 40'h00_4214_1414);
      mx(40'h00_E804_0000, 16'h0001, 40'h00_7402_0000);
      mx(40'h0, 16'hFFE1, 40'h0);
      chk("mem_n", 40'(n_st), 40'(n_seen));
      chk("mem_w", 40'hFFFF, {24'h00_0000, last_st});
      wrap_up();
   end
endmodule : tb_mac_parallel_load_store_datapath

bind mac_parallel_load_store_datapath mac_dp_properties u_props (.*);
`default_nettype wire
